//--- serializer_pkg.sv
package serializer_pkg;
    localparam int unsigned DATA_BITS = 21;
    localparam int unsigned LANES = 3;
    localparam int unsigned SLICE_BITS = 7;
    localparam int unsigned PERIOD_W = 8;
    localparam int unsigned ACC_W = 9;
    localparam logic [ACC_W-1:0] BIT_STEP = 9'h007;
    localparam logic [2:0] LAST_BIT = 3'h6;
    localparam logic [2:0] CLK_HIGH_LAST = 3'h3;
    localparam int unsigned SYNC_W = 23;
    localparam int unsigned SYNC_CLK = 21;
    localparam int unsigned SYNC_SHDN = 22;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned LOCK_MIN_MHZ = 20;
    localparam int unsigned LOCK_MAX_MHZ = 68;
    localparam logic [PERIOD_W-1:0] LOCK_MIN_PERIOD_CYC = 8'h07;
    localparam logic [PERIOD_W-1:0] LOCK_MAX_PERIOD_CYC = 8'hF0;
    localparam logic [PERIOD_W-1:0] PERIOD_SAT = 8'hFF;
    localparam logic [PERIOD_W-1:0] PERIOD_ONE = 8'h01;
    typedef enum logic [1:0]
    {
        ST_OFF = 2'b00,
        ST_ACQUIRE = 2'b01,
        ST_LOCKED = 2'b11
    } lock_state_t;
endpackage : serializer_pkg

//--- word_buffer.sv
`timescale 1ns/1ps
module word_buffer
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [serializer_pkg::DATA_BITS-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [serializer_pkg::DATA_BITS-1:0] out_data
);
    logic [serializer_pkg::DATA_BITS-1:0] mem [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end
        else if (clear)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 2'h1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule : word_buffer

//--- lvds_21to3_serializer.sv
// Function
// - capture 21 inputs each load clock rise while locked
// - three 7-bit load-and-shift lane registers
// - seven bits per load clock period: the edge plus six bit ticks
// - three lanes plus clock to drivers
// - forwarded clock matches load clock frequency
// - shutdown stops clocking, disables drivers
// - shutdown clears lock, counters, lanes and buffer pointers
// - lock only inside allowed clock range
// - 21 channels compressed onto 3 lanes
// - bit k launched k sevenths after edge
`timescale 1ns/1ps
module lvds_21to3_serializer
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic parallel_load_clock,
    input wire logic shutdown_clear_n,
    input wire logic [serializer_pkg::DATA_BITS-1:0] parallel_in,
    output logic lane0_pos,
    output logic lane0_neg,
    output logic lane1_pos,
    output logic lane1_neg,
    output logic lane2_pos,
    output logic lane2_neg,
    output logic forwarded_link_clock_pos,
    output logic forwarded_link_clock_neg,
    output logic line_driver_oe,
    output logic link_locked,
    output logic capture_overrun
);
    localparam int unsigned DB = serializer_pkg::DATA_BITS;
    localparam int unsigned SB = serializer_pkg::SLICE_BITS;

    function automatic logic period_ok(input logic [serializer_pkg::PERIOD_W-1:0] p);
        period_ok = (p >= serializer_pkg::LOCK_MIN_PERIOD_CYC)
            && (p <= serializer_pkg::LOCK_MAX_PERIOD_CYC);
    endfunction : period_ok

    logic [serializer_pkg::SYNC_W-1:0] sync1_reg;
    logic [serializer_pkg::SYNC_W-1:0] sync2_reg;
    logic [serializer_pkg::SYNC_W-1:0] sync3_reg;
    logic load_clk_level_reg;
    logic shdn_n_level_reg;
    logic load_edge;
    logic shut;
    serializer_pkg::lock_state_t state_reg;
    logic seen_edge_reg;
    logic [serializer_pkg::PERIOD_W-1:0] per_cnt_reg;
    logic [serializer_pkg::PERIOD_W-1:0] period_reg;
    logic [serializer_pkg::PERIOD_W-1:0] period_now;
    logic [serializer_pkg::ACC_W-1:0] acc_reg;
    logic [serializer_pkg::ACC_W-1:0] acc_sum;
    logic [2:0] bit_idx_reg;
    logic bit_tick;
    logic locked;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [DB-1:0] buf_out_data;
    logic [DB-1:0] frame_word;
    logic [serializer_pkg::LANES-1:0] lane_bit_reg;
    logic fwd_clk_reg;
    logic oe_reg;
    logic overrun_reg;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end
        else
        begin
            sync1_reg <= {shutdown_clear_n, parallel_load_clock, parallel_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a level only changes once stages two and three agree, rejecting a metastable glitch
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            load_clk_level_reg <= 1'b0;
            shdn_n_level_reg <= 1'b0;
        end
        else
        begin
            if (sync2_reg[serializer_pkg::SYNC_CLK] == sync3_reg[serializer_pkg::SYNC_CLK])
                load_clk_level_reg <= sync3_reg[serializer_pkg::SYNC_CLK];
            if (sync2_reg[serializer_pkg::SYNC_SHDN] == sync3_reg[serializer_pkg::SYNC_SHDN])
                shdn_n_level_reg <= sync3_reg[serializer_pkg::SYNC_SHDN];
        end
    end

    assign shut = !shdn_n_level_reg;
    assign load_edge = !shut && !load_clk_level_reg
        && sync2_reg[serializer_pkg::SYNC_CLK] && sync3_reg[serializer_pkg::SYNC_CLK];
    assign period_now = (per_cnt_reg == serializer_pkg::PERIOD_SAT) ? per_cnt_reg
        : per_cnt_reg + serializer_pkg::PERIOD_ONE;
    assign locked = (state_reg == serializer_pkg::ST_LOCKED);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            per_cnt_reg <= '0;
            period_reg <= '0;
        end
        else if (shut)
        begin
            per_cnt_reg <= '0;
            period_reg <= '0;
        end
        else if (load_edge)
        begin
            per_cnt_reg <= '0;
            period_reg <= period_now;
        end
        else if (per_cnt_reg != serializer_pkg::PERIOD_SAT)
        begin
            per_cnt_reg <= per_cnt_reg + serializer_pkg::PERIOD_ONE;
        end
    end

    // lock needs one full measured period inside the window; a stopped clock drops it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= serializer_pkg::ST_OFF;
            seen_edge_reg <= 1'b0;
        end
        else if (shut)
        begin
            state_reg <= serializer_pkg::ST_OFF;
            seen_edge_reg <= 1'b0;
        end
        else
        begin
            if (load_edge)
                seen_edge_reg <= 1'b1;
            case (state_reg)
                serializer_pkg::ST_OFF:
                    state_reg <= serializer_pkg::ST_ACQUIRE;
                serializer_pkg::ST_ACQUIRE:
                    if (load_edge && seen_edge_reg && period_ok(period_now))
                        state_reg <= serializer_pkg::ST_LOCKED;
                serializer_pkg::ST_LOCKED:
                    if ((load_edge && !period_ok(period_now))
                        || per_cnt_reg > serializer_pkg::LOCK_MAX_PERIOD_CYC)
                        state_reg <= serializer_pkg::ST_ACQUIRE;
                default:
                    state_reg <= serializer_pkg::ST_OFF;
            endcase
        end
    end

    // fractional divider: adds seven per cycle, one tick per period's worth, restarted by the edge
    assign acc_sum = acc_reg + serializer_pkg::BIT_STEP;
    assign bit_tick = locked && !load_edge && (bit_idx_reg != serializer_pkg::LAST_BIT)
        && (acc_sum >= {1'b0, period_reg});

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_reg <= '0;
            bit_idx_reg <= serializer_pkg::LAST_BIT;
        end
        else if (shut || load_edge)
        begin
            // the locking edge loads nothing, so it must not start a partial frame of ticks
            acc_reg <= '0;
            bit_idx_reg <= (load_edge && locked) ? 3'h0 : serializer_pkg::LAST_BIT;
        end
        else if (locked && bit_idx_reg != serializer_pkg::LAST_BIT)
        begin
            if (bit_tick)
            begin
                acc_reg <= acc_sum - {1'b0, period_reg};
                bit_idx_reg <= bit_idx_reg + 3'h1;
            end
            else
                acc_reg <= acc_sum;
        end
    end

    // the drain is ready only at a locked frame edge, so the buffer absorbs a late frame start
    word_buffer u_buffer
    (
        .clk(clk),
        .rst_b(rst_b),
        .clear(shut),
        .in_valid(load_edge && locked),
        .in_ready(buf_in_ready),
        .in_data(sync3_reg[DB-1:0]),
        .out_valid(buf_out_valid),
        .out_ready(load_edge && locked),
        .out_data(buf_out_data)
    );

    assign frame_word = buf_out_valid ? buf_out_data : '0;

    genvar lane;
    generate
        for (lane = 0; lane < serializer_pkg::LANES; lane++)
        begin : g_lane
            logic [SB-1:0] shift_reg;
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    shift_reg <= '0;
                    lane_bit_reg[lane] <= 1'b0;
                end
                else if (shut || !locked)
                begin
                    shift_reg <= '0;
                    lane_bit_reg[lane] <= 1'b0;
                end
                else if (load_edge)
                begin
                    // lane l carries inputs 7l..7l+6, lowest bit first
                    shift_reg <= {1'b0, frame_word[lane*SB+1 +: SB-1]};
                    lane_bit_reg[lane] <= frame_word[lane*SB];
                end
                else if (bit_tick)
                begin
                    shift_reg <= {1'b0, shift_reg[SB-1:1]};
                    lane_bit_reg[lane] <= shift_reg[0];
                end
            end
        end
    endgenerate

    // forwarded clock: high for bits 0..3, low for 4..6, one cycle per load period
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fwd_clk_reg <= 1'b0;
        else if (shut || !locked)
            fwd_clk_reg <= 1'b0;
        else if (load_edge)
            fwd_clk_reg <= 1'b1;
        else if (bit_tick)
            fwd_clk_reg <= (bit_idx_reg + 3'h1) <= serializer_pkg::CLK_HIGH_LAST;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oe_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end
        else
        begin
            oe_reg <= !shut && locked;
            if (shut)
                overrun_reg <= 1'b0;
            else if (load_edge && locked && !buf_in_ready)
                overrun_reg <= 1'b1;
        end
    end

    // outputs sit one cycle behind the internal bit so each pin is a flop and the pair stays aligned
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {lane0_pos, lane0_neg, lane1_pos, lane1_neg, lane2_pos, lane2_neg,
                forwarded_link_clock_pos, forwarded_link_clock_neg, line_driver_oe,
                link_locked, capture_overrun} <= 11'h000;
        end
        else
        begin
            lane0_pos <= oe_reg && lane_bit_reg[0];
            lane0_neg <= oe_reg && !lane_bit_reg[0];
            lane1_pos <= oe_reg && lane_bit_reg[1];
            lane1_neg <= oe_reg && !lane_bit_reg[1];
            lane2_pos <= oe_reg && lane_bit_reg[2];
            lane2_neg <= oe_reg && !lane_bit_reg[2];
            forwarded_link_clock_pos <= oe_reg && fwd_clk_reg;
            forwarded_link_clock_neg <= oe_reg && !fwd_clk_reg;
            line_driver_oe <= oe_reg;
            link_locked <= locked;
            capture_overrun <= overrun_reg;
        end
    end
endmodule : lvds_21to3_serializer

//--- lvds_21to3_serializer_asserts.sv
`timescale 1ns/1ps
module lvds_21to3_serializer_asserts
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic parallel_load_clock,
    input wire logic shutdown_clear_n,
    input wire logic lane0_pos,
    input wire logic lane0_neg,
    input wire logic lane1_pos,
    input wire logic lane1_neg,
    input wire logic lane2_pos,
    input wire logic lane2_neg,
    input wire logic forwarded_link_clock_pos,
    input wire logic forwarded_link_clock_neg,
    input wire logic line_driver_oe,
    input wire logic link_locked,
    input wire logic capture_overrun
);
    logic [8:0] idle_cnt_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // clk cycles since the last load clock rise, saturating
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            idle_cnt_reg <= 9'h000;
        else if ($rose(parallel_load_clock))
            idle_cnt_reg <= 9'h000;
        else if (idle_cnt_reg != 9'h1FF)
            idle_cnt_reg <= idle_cnt_reg + 9'h001;
    end
    sequence fwd_high_run;
        (forwarded_link_clock_pos || !line_driver_oe) [*4];
    endsequence
    sequence fwd_low_run;
        !forwarded_link_clock_pos [*3];
    endsequence
    sequence fwd_launch;
        ##[2:8] ($rose(forwarded_link_clock_pos) || !line_driver_oe);
    endsequence
    sequence held_shutdown;
        !shutdown_clear_n [*8];
    endsequence
    chk_off_all_quiet: assert property (!line_driver_oe |-> {lane0_pos, lane0_neg, lane1_pos,
        lane1_neg, lane2_pos, lane2_neg, forwarded_link_clock_pos, forwarded_link_clock_neg} == 8'h00)
        else $error("outputs active while drivers off");
    chk_lane_pair_diff: assert property (line_driver_oe |-> lane0_neg != lane0_pos &&
        lane1_neg != lane1_pos && lane2_neg != lane2_pos
        && forwarded_link_clock_neg != forwarded_link_clock_pos)
        else $error("pair halves not complementary");
    chk_shutdown_clears: assert property (held_shutdown |-> !link_locked && !line_driver_oe
        && !capture_overrun)
        else $error("state survives shutdown");
    chk_fwd_high_span: assert property ($rose(forwarded_link_clock_pos) && $past(line_driver_oe)
        |-> fwd_high_run)
        else $error("forwarded clock high too short");
    chk_fwd_low_span: assert property ($fell(forwarded_link_clock_pos) && line_driver_oe
        |-> fwd_low_run)
        else $error("forwarded clock low too short");
    chk_fwd_follows_load: assert property ($rose(parallel_load_clock) && line_driver_oe
        |-> fwd_launch)
        else $error("no forwarded clock for load edge");
    chk_stall_unlocks: assert property (idle_cnt_reg > 9'h104 |-> !link_locked)
        else $error("lock kept without load clock");
    chk_oe_drop_lock: assert property ($fell(link_locked) |-> ##[0:2] !line_driver_oe)
        else $error("drivers stay on after lock loss");
endmodule : lvds_21to3_serializer_asserts

bind lvds_21to3_serializer lvds_21to3_serializer_asserts chk_i (.clk, .rst_b,
    .parallel_load_clock, .shutdown_clear_n, .lane0_pos, .lane0_neg, .lane1_pos, .lane1_neg,
    .lane2_pos, .lane2_neg, .forwarded_link_clock_pos, .forwarded_link_clock_neg,
    .line_driver_oe, .link_locked, .capture_overrun);

//--- link_receiver_model.sv
`timescale 1ns/1ps
module link_receiver_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic lane0_pos,
    input wire logic lane1_pos,
    input wire logic lane2_pos,
    input wire logic forwarded_link_clock_pos,
    output logic [serializer_pkg::DATA_BITS-1:0] rx_word,
    output logic rx_strobe
);
    // bit 0 is taken when the clock rise shows, bit k k+1 cycles later; a frame cut short
    // by an early edge is dropped rather than patched
    logic fwd_prev;
    logic [3:0] pos_cnt;
    logic [6:0] acc0, acc1, acc2;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fwd_prev <= 1'b0;
            pos_cnt <= 4'h0;
            {acc2, acc1, acc0} <= '0;
            rx_word <= '0;
            rx_strobe <= 1'b0;
        end
        else
        begin
            fwd_prev <= forwarded_link_clock_pos;
            rx_strobe <= 1'b0;
            if (forwarded_link_clock_pos && !fwd_prev)
            begin
                pos_cnt <= 4'h1;
                {acc2[0], acc1[0], acc0[0]} <= {lane2_pos, lane1_pos, lane0_pos};
            end
            else if (pos_cnt == 4'h7)
            begin
                pos_cnt <= 4'h0;
                rx_strobe <= 1'b1;
                rx_word <= {lane2_pos, acc2[5:0], lane1_pos, acc1[5:0], lane0_pos, acc0[5:0]};
            end
            else if (pos_cnt != 4'h0)
            begin
                pos_cnt <= pos_cnt + 4'h1;
                if (pos_cnt > 4'h1)
                    {acc2[pos_cnt-4'h1], acc1[pos_cnt-4'h1], acc0[pos_cnt-4'h1]} <= {lane2_pos, lane1_pos, lane0_pos};
            end
        end
    end
endmodule : link_receiver_model

//--- lvds_21to3_serializer_tb_top.sv
`timescale 1ns/1ps
module lvds_21to3_serializer_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic parallel_load_clock = 1'b0;
    logic shutdown_clear_n = 1'b1;
    logic [serializer_pkg::DATA_BITS-1:0] parallel_in = '0;
    logic lane0_pos, lane0_neg, lane1_pos, lane1_neg, lane2_pos, lane2_neg;
    logic forwarded_link_clock_pos, forwarded_link_clock_neg;
    logic line_driver_oe, link_locked, capture_overrun, rx_strobe;
    logic [serializer_pkg::DATA_BITS-1:0] rx_word;
    logic [serializer_pkg::DATA_BITS-1:0] tx_q[$];
    logic [serializer_pkg::DATA_BITS-1:0] rx_q[$];
    logic load_run = 1'b0;
    time last_rise = 0;
    time last_gap = 0;
    int half = 4;
    int ph = 0;
    int error_cnt = 0;
    int comparisons = 0;
    wire [10:0] outs = {lane0_pos, lane0_neg, lane1_pos, lane1_neg, lane2_pos, lane2_neg,
        forwarded_link_clock_pos, forwarded_link_clock_neg, line_driver_oe, link_locked,
        capture_overrun};

    lvds_21to3_serializer uut (.clk, .rst_b, .parallel_load_clock, .shutdown_clear_n,
        .parallel_in, .lane0_pos, .lane0_neg, .lane1_pos, .lane1_neg, .lane2_pos, .lane2_neg,
        .forwarded_link_clock_pos, .forwarded_link_clock_neg, .line_driver_oe, .link_locked,
        .capture_overrun);
    link_receiver_model rx (.clk, .rst_b, .lane0_pos, .lane1_pos, .lane2_pos,
        .forwarded_link_clock_pos, .rx_word, .rx_strobe);

    always #50 clk = ~clk;

    // data changes on the load clock fall so it is settled well before the next rise
    always @(negedge clk)
    begin
        if (load_run)
        begin
            ph <= (ph >= half - 1) ? 0 : ph + 1;
            if (ph >= half - 1)
            begin
                parallel_load_clock <= ~parallel_load_clock;
                if (parallel_load_clock)
                    parallel_in <= (tx_q.size() > 0) ? tx_q.pop_front() : '0;
            end
        end
    end

    always @(posedge clk)
    begin
        if (rx_strobe === 1'b1)
            rx_q.push_back(rx_word);
    end

    always @(posedge forwarded_link_clock_pos)
    begin
        last_gap = $time - last_rise;
        last_rise = $time;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic wait_lock(input logic want, input int bound);
        int n = 0;
        while (link_locked !== want && n < bound)
        begin
            @(negedge clk);
            n++;
        end
        check("link_locked", link_locked, want);
        if (link_locked !== want)
            tally_and_finish();
    endtask : wait_lock

    task automatic test_reset;
        check("outputs after reset", outs, 0);
    endtask : test_reset

    task automatic test_stream;
        logic [serializer_pkg::DATA_BITS-1:0] w[7];
        int i = 0;
        w = '{21'h1ABCDE, 21'h1FFFFF, 21'h000001, 21'h100000, 21'h155555, 21'h0AAAAA, 21'h0F0F0F};
        repeat (48) @(negedge clk);
        rx_q.delete();
        foreach (w[k]) tx_q.push_back(w[k]);
        repeat (96) @(negedge clk);
        while (i < rx_q.size() && rx_q[i] === '0) i++;
        foreach (w[k]) check("word", (i + k < rx_q.size()) ? rx_q[i + k] : 'x, w[k]);
        check("link clock period ns", last_gap, 800);
        check("overrun", capture_overrun, 0);
    endtask : test_stream

    task automatic test_shutdown;
        logic [10:0] acc = '0;
        shutdown_clear_n = 1'b0;
        repeat (10) @(negedge clk);
        repeat (24)
        begin
            acc = acc | outs;
            @(negedge clk);
        end
        check("outputs in shutdown", acc, 0);
        shutdown_clear_n = 1'b1;
        wait_lock(1'b1, 200);
        test_stream();
    endtask : test_shutdown

    task automatic test_stall;
        load_run = 1'b0;
        wait_lock(1'b0, 300);
        // the driver enable pin follows the lock flag one cycle later
        repeat (2) @(negedge clk);
        check("driver enable", line_driver_oe, 0);
    endtask : test_stall

    task automatic test_fast;
        logic acc = 1'b0;
        half = 2;
        load_run = 1'b1;
        repeat (100)
        begin
            acc = acc | link_locked;
            @(negedge clk);
        end
        check("lock at short period", acc, 0);
        half = 4;
        wait_lock(1'b1, 100);
    endtask : test_fast

    initial
    begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        test_reset();
        load_run = 1'b1;
        wait_lock(1'b1, 100);
        test_stream();
        test_shutdown();
        test_stall();
        test_fast();
        tally_and_finish();
    end
endmodule : lvds_21to3_serializer_tb_top
